// file: fcd_pkg.sv
package fcd_pkg;
   // register space offsets, matched on haddr or d_addr bits [18:0], [18:2] or [18:7]
   localparam logic [18:0] OFF_CMD = 19'h0_0148;
   localparam logic [18:0] OFF_STATUS = 19'h0_0120;
   localparam logic [18:0] OFF_CLEAR = 19'h0_0124;
   localparam logic [18:0] OFF_DWCOUNT = 19'h0_014c;
   localparam logic [18:0] OFF_WSB = 19'h0_0080;
   localparam logic [18:0] OFF_SPB = 19'h0_0200;
   // command word fields
   localparam int CMD_OP_HI = 31;
   localparam int CMD_OP_LO = 24;
   localparam int CMD_PAGE_HI = 17;
   localparam int CMD_PAGE_LO = 7;
   localparam int CMD_DW_HI = 6;
   localparam int CMD_DW_LO = 3;
   // operation codes
   localparam logic [7:0] OP_PROG_ADDR = 8'h05;
   localparam logic [7:0] OP_PROG_LOAD = 8'h06;
   localparam logic [7:0] OP_PROG_GO = 8'h07;
   localparam logic [7:0] OP_PROG_ALL = 8'h08;
   localparam logic [7:0] OP_VER_ADDR = 8'h0d;
   localparam logic [7:0] OP_VER_LOAD = 8'h0e;
   localparam logic [7:0] OP_VER_GO = 8'h0f;
   localparam logic [7:0] OP_VER_ALL = 8'h10;
   localparam logic [7:0] OP_UNLOCK = 8'h13;
   // status and clear bit positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DENIED_BIT = 1;
   localparam int ST_MISMATCH_BIT = 2;
   localparam int CLR_DENIED_BIT = 1;
   localparam int CLR_MISMATCH_BIT = 2;
   // reset values and sizes
   localparam logic [4:0] DWCOUNT_RST = 5'h10;
   localparam logic [4:0] PAGE_DWORDS = 5'h10;
   localparam logic [2:0] RB_BURST_DWORDS = 3'h4;
   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HBURST_WRAP8 = 3'h4;
   localparam logic [2:0] HBURST_INCR8 = 3'h5;
   // array operation codes
   localparam logic [1:0] AOP_PROGRAM = 2'h0;
   localparam logic [1:0] AOP_VERIFY = 2'h1;
   localparam logic [1:0] AOP_UNLOCK = 2'h2;

   typedef enum logic [1:0] {
      DP_IDLE = 2'b00,
      DP_RDWAIT = 2'b01,
      DP_ERR1 = 2'b10,
      DP_ERR2 = 2'b11
   } fcd_dp_state_type;

   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_COPY = 2'b01,
      OP_LAUNCH = 2'b10,
      OP_WAIT = 2'b11
   } fcd_op_state_type;
endpackage

// file: fcd_cmd_decode.sv
module fcd_cmd_decode (
   input wire logic [31:0] cmd, // assembled command word
   output logic known, // opcode recognised
   output logic latch_page, // opcode carries a page address
   output logic copy_en, // opcode copies staging data
   output logic copy_full, // copy the whole page
   output logic start, // opcode starts an array operation
   output logic verify, // verify family
   output logic unlock, // page unlock
   output logic [10:0] page, // page address field
   output logic [3:0] dw_start // first destination dword
);
   wire [7:0] op = cmd[fcd_pkg::CMD_OP_HI:fcd_pkg::CMD_OP_LO];
   wire p_addr = op == fcd_pkg::OP_PROG_ADDR;
   wire p_load = op == fcd_pkg::OP_PROG_LOAD;
   wire p_go = op == fcd_pkg::OP_PROG_GO;
   wire p_all = op == fcd_pkg::OP_PROG_ALL;
   wire v_addr = op == fcd_pkg::OP_VER_ADDR;
   wire v_load = op == fcd_pkg::OP_VER_LOAD;
   wire v_go = op == fcd_pkg::OP_VER_GO;
   wire v_all = op == fcd_pkg::OP_VER_ALL;

   assign unlock = op == fcd_pkg::OP_UNLOCK;
   assign known = p_addr | p_load | p_go | p_all | v_addr | v_load | v_go | v_all | unlock;
   assign latch_page = p_addr | p_all | v_addr | v_all;
   assign copy_en = p_load | v_load | p_all | v_all;
   assign copy_full = p_all | v_all;
   assign start = p_go | p_all | v_go | v_all | unlock;
   assign verify = v_addr | v_load | v_go | v_all;
   // low address bits below the page are dropped
   assign page = cmd[fcd_pkg::CMD_PAGE_HI:fcd_pkg::CMD_PAGE_LO];
   assign dw_start = v_load ? cmd[fcd_pkg::CMD_DW_HI:fcd_pkg::CMD_DW_LO] : 4'h0;
endmodule

// file: fcd_read_buffer.sv
module fcd_read_buffer (
   input wire logic clock, // bus clock
   input wire logic arst_n, // async reset
   input wire logic [17:2] look_addr, // word address looked up
   input wire logic fetch, // fill on miss allowed
   input wire logic burst_fill, // fill the whole line
   input wire logic flush, // drop all contents
   output logic hit, // looked-up word present
   output logic [31:0] word, // looked-up word
   output logic arr_rd_req, // array read request
   output logic [17:3] arr_rd_addr, // array dword address
   input wire logic arr_rd_ack, // array data valid
   input wire logic [63:0] arr_rd_data // array dword
);
   logic [31:0] mem [0:7];
   logic [17:5] tag;
   logic [3:0] valid;
   logic [1:0] fill_dw;
   logic [2:0] fill_left;

   wire tag_match = tag == look_addr[17:5];
   wire start_fill = fetch & ~hit & (fill_left == 3'h0);
   wire beat = arr_rd_ack & arr_rd_req;

   assign hit = tag_match & valid[look_addr[4:3]];
   assign word = mem[look_addr[4:2]];
   assign arr_rd_req = fill_left != 3'h0;
   assign arr_rd_addr = {tag, fill_dw};

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tag <= 13'h0;
         fill_dw <= 2'h0;
         fill_left <= 3'h0;
         valid <= 4'h0;
      end else begin
         if (start_fill) begin
            tag <= look_addr[17:5];
            fill_dw <= look_addr[4:3];
            fill_left <= burst_fill ? fcd_pkg::RB_BURST_DWORDS : 3'h1;
         end else if (beat) begin
            fill_dw <= fill_dw + 2'h1;
            fill_left <= fill_left - 3'h1;
         end
         if (flush | (start_fill & ~tag_match)) begin
            valid <= 4'h0;
         end else if (beat) begin
            valid <= valid | (4'h1 << fill_dw);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (beat) begin
         mem[{fill_dw, 1'b0}] <= arr_rd_data[31:0];
         mem[{fill_dw, 1'b1}] <= arr_rd_data[63:32];
      end
   end
endmodule

// file: fcd_flash_command_decoder.sv
module fcd_flash_command_decoder (
   input wire logic clock, // bus clock
   input wire logic arst_n, // async reset
   input wire logic hsel_array, // select, array space
   input wire logic hsel_ctrl, // select, register space
   input wire logic [18:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write transfer
   input wire logic [2:0] hsize, // transfer size
   input wire logic [2:0] hburst, // burst type
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic hreadyout, // slave ready
   output logic hresp, // error response
   output logic [31:0] hrdata, // read data
   output logic arr_op_start, // array operation pulse
   output logic [1:0] arr_op_code, // program, verify, unlock
   output logic [10:0] arr_op_page, // page address
   input wire logic arr_op_done, // array operation finished
   input wire logic arr_op_mismatch, // verify failed, with done
   input wire logic [3:0] arr_stage_idx, // staging dword index
   output logic [63:0] arr_stage_data, // staging dword
   output logic arr_rd_req, // array read request
   output logic [17:3] arr_rd_addr, // array dword address
   input wire logic arr_rd_ack, // array data valid
   input wire logic [63:0] arr_rd_data // array dword
);
   fcd_pkg::fcd_dp_state_type dp_state, next_dp_state;
   fcd_pkg::fcd_op_state_type op_state, next_op_state;
   logic [31:0] write_stage_buffer [0:31];
   logic [31:0] staging_page_buffer [0:31];
   logic d_wr;
   logic [18:0] d_addr;
   logic [3:0] d_be;
   logic d_burst;
   logic [31:0] cmd_shadow;
   logic [4:0] dword_count;
   logic denied;
   logic mismatch;
   logic [10:0] page;
   logic op_verify;
   logic op_unlock;
   logic start_after;
   logic [3:0] copy_src;
   logic [3:0] copy_dst;
   logic [4:0] copy_left;
   logic [31:0] cmd_word;
   logic [31:0] wsb_merge;
   logic [31:0] reg_rdata;
   logic [3:0] be;
   logic rb_hit;
   logic [31:0] rb_word;
   logic dec_known, dec_latch, dec_copy, dec_full, dec_start, dec_verify, dec_unlock;
   logic [10:0] dec_page;
   logic [3:0] dec_dw;

   // address phase
   wire busy = op_state != fcd_pkg::OP_IDLE;
   wire take = hready & htrans[1] & (hsel_array | hsel_ctrl);
   wire take_arr_wr = take & hsel_array & hwrite;
   wire take_arr_rd = take & hsel_array & ~hwrite;
   wire take_reg = take & hsel_ctrl & ~hsel_array;
   wire waiting = dp_state == fcd_pkg::DP_RDWAIT;
   wire [17:2] look_addr = waiting ? d_addr[17:2] : haddr[17:2];
   wire rd_ok = rb_hit & ~busy;
   wire load_arr = (waiting | (hreadyout & take_arr_rd)) & rd_ok;
   wire load_reg = hreadyout & take_reg & ~hwrite;
   wire burst8 = (htrans == fcd_pkg::HTRANS_NONSEQ)
      & ((hburst == fcd_pkg::HBURST_WRAP8) | (hburst == fcd_pkg::HBURST_INCR8));

   assign be = (hsize == 3'h0) ? (4'h1 << haddr[1:0])
      : (hsize == 3'h1) ? (haddr[1] ? 4'hc : 4'h3) : 4'hf;

   // register read decode
   wire rd_status = haddr == fcd_pkg::OFF_STATUS;
   wire rd_count = haddr == fcd_pkg::OFF_DWCOUNT;
   wire rd_wsb = haddr[18:7] == fcd_pkg::OFF_WSB[18:7];
   wire rd_spb = haddr[18:7] == fcd_pkg::OFF_SPB[18:7];
   wire [31:0] status_word = {29'h0, mismatch, denied, busy};

   assign reg_rdata = rd_status ? status_word
      : rd_count ? {27'h0, dword_count}
      : rd_spb ? staging_page_buffer[haddr[6:2]]
      : rd_wsb ? write_stage_buffer[haddr[6:2]] : 32'h0;

   // data phase write decode
   wire wr_cmd = d_wr & (d_addr[18:2] == fcd_pkg::OFF_CMD[18:2]);
   wire launch = wr_cmd & d_be[0];
   wire wr_clear = d_wr & (d_addr[18:2] == fcd_pkg::OFF_CLEAR[18:2]) & d_be[0];
   wire wr_count = d_wr & (d_addr[18:2] == fcd_pkg::OFF_DWCOUNT[18:2]) & d_be[0];
   wire wr_wsb = d_wr & (d_addr[18:7] == fcd_pkg::OFF_WSB[18:7]);
   wire deny = launch & (busy | denied);
   wire go = launch & ~busy & ~denied & dec_known;
   wire copy_step = (op_state == fcd_pkg::OP_COPY) & (copy_left != 5'h0);
   wire op_end = (op_state == fcd_pkg::OP_WAIT) & arr_op_done;
   wire flush = op_end & ~op_verify & ~op_unlock;
   wire mism_set = op_end & op_verify & arr_op_mismatch;
   wire clr_denied = wr_clear & hwdata[fcd_pkg::CLR_DENIED_BIT];
   wire clr_mism = wr_clear & hwdata[fcd_pkg::CLR_MISMATCH_BIT];
   wire [4:0] load_count = (dword_count > fcd_pkg::PAGE_DWORDS) ? fcd_pkg::PAGE_DWORDS : dword_count;

   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign cmd_word[8*b +: 8] = d_be[b] ? hwdata[8*b +: 8] : cmd_shadow[8*b +: 8];
      assign wsb_merge[8*b +: 8] = d_be[b] ? hwdata[8*b +: 8]
         : write_stage_buffer[d_addr[6:2]][8*b +: 8];
   end

   fcd_cmd_decode u_dec (
      .cmd(cmd_word),
      .known(dec_known),
      .latch_page(dec_latch),
      .copy_en(dec_copy),
      .copy_full(dec_full),
      .start(dec_start),
      .verify(dec_verify),
      .unlock(dec_unlock),
      .page(dec_page),
      .dw_start(dec_dw)
   );

   fcd_read_buffer u_rb (
      .clock(clock),
      .arst_n(arst_n),
      .look_addr(look_addr),
      .fetch(waiting & ~busy),
      .burst_fill(d_burst),
      .flush(flush),
      .hit(rb_hit),
      .word(rb_word),
      .arr_rd_req(arr_rd_req),
      .arr_rd_addr(arr_rd_addr),
      .arr_rd_ack(arr_rd_ack),
      .arr_rd_data(arr_rd_data)
   );

   // bus data phase
   always_comb begin
      next_dp_state = dp_state;
      case (dp_state)
         fcd_pkg::DP_RDWAIT: begin
            if (rd_ok) begin
               next_dp_state = fcd_pkg::DP_IDLE;
            end
         end
         fcd_pkg::DP_ERR1: begin
            next_dp_state = fcd_pkg::DP_ERR2;
         end
         default: begin
            if (take_arr_wr) begin
               next_dp_state = fcd_pkg::DP_ERR1;
            end else if (take_arr_rd & ~rd_ok) begin
               next_dp_state = fcd_pkg::DP_RDWAIT;
            end else begin
               next_dp_state = fcd_pkg::DP_IDLE;
            end
         end
      endcase
   end

   assign hreadyout = (dp_state == fcd_pkg::DP_IDLE) | (dp_state == fcd_pkg::DP_ERR2);
   assign hresp = (dp_state == fcd_pkg::DP_ERR1) | (dp_state == fcd_pkg::DP_ERR2);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dp_state <= fcd_pkg::DP_IDLE;
         d_wr <= 1'b0;
         d_addr <= 19'h0_0000;
         d_be <= 4'h0;
         d_burst <= 1'b0;
      end else begin
         dp_state <= next_dp_state;
         if (hreadyout) begin
            d_wr <= take_reg & hwrite;
            d_addr <= haddr;
            d_be <= be;
            d_burst <= burst8;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (load_arr) begin
         hrdata <= rb_word;
      end else if (load_reg) begin
         hrdata <= reg_rdata;
      end
   end

   // control and status
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         denied <= 1'b0;
         mismatch <= 1'b0;
         dword_count <= fcd_pkg::DWCOUNT_RST;
         cmd_shadow <= 32'h0000_0000;
      end else begin
         denied <= deny | (denied & ~clr_denied);
         mismatch <= mism_set | (mismatch & ~clr_mism);
         if (wr_cmd) begin
            cmd_shadow <= cmd_word;
         end
         if (wr_count) begin
            dword_count <= hwdata[4:0];
         end
      end
   end

   // operation sequencer
   always_comb begin
      next_op_state = op_state;
      case (op_state)
         fcd_pkg::OP_IDLE: begin
            if (go) begin
               next_op_state = dec_copy ? fcd_pkg::OP_COPY
                  : dec_start ? fcd_pkg::OP_LAUNCH : fcd_pkg::OP_IDLE;
            end
         end
         fcd_pkg::OP_COPY: begin
            if (copy_left == 5'h0) begin
               next_op_state = start_after ? fcd_pkg::OP_LAUNCH : fcd_pkg::OP_IDLE;
            end
         end
         fcd_pkg::OP_LAUNCH: begin
            next_op_state = fcd_pkg::OP_WAIT;
         end
         default: begin
            if (arr_op_done) begin
               next_op_state = fcd_pkg::OP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         op_state <= fcd_pkg::OP_IDLE;
         page <= 11'h000;
         op_verify <= 1'b0;
         op_unlock <= 1'b0;
         start_after <= 1'b0;
         copy_src <= 4'h0;
         copy_dst <= 4'h0;
         copy_left <= 5'h00;
      end else begin
         op_state <= next_op_state;
         if (go) begin
            if (dec_latch) begin
               page <= dec_page;
            end
            op_verify <= dec_verify;
            op_unlock <= dec_unlock;
            start_after <= dec_start;
            copy_src <= 4'h0;
            copy_dst <= dec_dw;
            copy_left <= dec_full ? fcd_pkg::PAGE_DWORDS : load_count;
         end else if (copy_step) begin
            copy_src <= copy_src + 4'h1;
            copy_dst <= copy_dst + 4'h1;
            copy_left <= copy_left - 5'h01;
         end
      end
   end

   // buffers hold no reset state
   always_ff @(posedge clock) begin
      if (wr_wsb) begin
         write_stage_buffer[d_addr[6:2]] <= wsb_merge;
      end
   end

   always_ff @(posedge clock) begin
      if (copy_step) begin
         staging_page_buffer[{copy_dst, 1'b0}] <= write_stage_buffer[{copy_src, 1'b0}];
         staging_page_buffer[{copy_dst, 1'b1}] <= write_stage_buffer[{copy_src, 1'b1}];
      end
   end

   // array side; stage data is whatever the buffer holds now
   assign arr_op_start = op_state == fcd_pkg::OP_LAUNCH;
   assign arr_op_code = op_unlock ? fcd_pkg::AOP_UNLOCK
      : op_verify ? fcd_pkg::AOP_VERIFY : fcd_pkg::AOP_PROGRAM;
   assign arr_op_page = page;
   assign arr_stage_data = {staging_page_buffer[{arr_stage_idx, 1'b1}],
      staging_page_buffer[{arr_stage_idx, 1'b0}]};
endmodule

// file: fcd_flash_command_decoder_checker.sv
module fcd_flash_command_decoder_checker (
   input wire logic clock, // bus clock
   input wire logic arst_n, // async reset
   input wire logic hsel_array, // array select
   input wire logic hsel_ctrl, // register select
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic hready, // ready in
   input wire logic hreadyout, // ready out
   input wire logic hresp, // error
   input wire logic arr_op_start, // op pulse
   input wire logic [1:0] arr_op_code, // op kind
   input wire logic [10:0] arr_op_page, // op page
   input wire logic arr_op_done, // op end
   input wire logic arr_rd_req, // read request
   input wire logic [17:3] arr_rd_addr, // read address
   input wire logic arr_rd_ack // read valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy;
   wire take = hready && htrans[1] && hreadyout;
   wire rd_take = take && hsel_array && !hwrite;
   wire wr_arr = take && hsel_array && hwrite;
   wire ctl_take = take && hsel_ctrl && !hsel_array;
   // array operation running, start pulse to done
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         busy <= 1'b0;
      else if (arr_op_start)
         busy <= 1'b1;
      else if (arr_op_done)
         busy <= 1'b0;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   reset_idle_a: assert property (disable iff (1'b0) !arst_n |-> hreadyout && !hresp && !arr_op_start && !arr_rd_req)
      else $error("outputs not idle in reset");
   busy_stall_a: assert property (busy && !arr_op_done && !arr_op_start && rd_take |=> !hreadyout)
      else $error("array read not stalled while busy");
   hit_fetch_a: assert property (!busy && !arr_op_start && rd_take |=> ##[0:1] (hreadyout || arr_rd_req))
      else $error("idle array read neither answered nor fetched");
   req_hold_a: assert property (arr_rd_req && !arr_rd_ack |=> arr_rd_req && $stable(arr_rd_addr))
      else $error("array read request dropped or moved");
   ack_ready_a: assert property (arr_rd_ack && !hreadyout && !busy |=> ##1 (hreadyout || arr_rd_req))
      else $error("read not answered after array data");
   err_two_a: assert property (wr_arr |=> !hreadyout && hresp ##1 hreadyout && hresp)
      else $error("array write not answered with error");
   err_only_a: assert property (hresp |-> $past(wr_arr) || $past(hresp) && !$past(hreadyout))
      else $error("error response without array write");
   ctl_zero_a: assert property (ctl_take |=> hreadyout && !hresp)
      else $error("register access stalled");
   no_restart_a: assert property (busy && !arr_op_done |-> !arr_op_start)
      else $error("operation started while busy");
   op_hold_a: assert property (busy && !arr_op_start |-> $stable(arr_op_code) && $stable(arr_op_page))
      else $error("operation code or page changed while busy");
   start_pulse_a: assert property (arr_op_start |-> arr_op_code != 2'h3 ##1 !arr_op_start)
      else $error("bad operation start pulse");
endmodule
bind fcd_flash_command_decoder fcd_flash_command_decoder_checker fcd_flash_command_decoder_checker_i (
   .clock, .arst_n, .hsel_array, .hsel_ctrl, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .arr_op_start, .arr_op_code, .arr_op_page, .arr_op_done, .arr_rd_req, .arr_rd_addr, .arr_rd_ack);

// file: fcd_array_model.sv
module fcd_array_model (
   input wire logic clock, // bus clock
   input wire logic arst_n, // async reset
   input wire logic [7:0] op_lat, // cycles per operation
   input wire logic [7:0] rd_lat, // cycles per dword read
   input wire logic arr_op_start, // op pulse
   input wire logic [1:0] arr_op_code, // op kind
   input wire logic [10:0] arr_op_page, // op page
   output logic arr_op_done, // op end
   output logic arr_op_mismatch, // verify failed
   output logic [3:0] arr_stage_idx, // staging index
   input wire logic [63:0] arr_stage_data, // staging dword
   input wire logic arr_rd_req, // read request
   input wire logic [17:3] arr_rd_addr, // read address
   output logic arr_rd_ack, // read valid
   output logic [63:0] arr_rd_data // read dword
);
   timeunit 1ns;
   timeprecision 1ns;
   int starts = 0, acks = 0, opc, rdc;
   logic [1:0] code;
   logic [10:0] page;
   logic [63:0] dw0;
   assign arr_stage_idx = 4'h0;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         opc = 0;
         rdc = 0;
         arr_op_done <= 1'b0;
         arr_op_mismatch <= 1'b0;
         arr_rd_ack <= 1'b0;
         arr_rd_data <= 64'h0000_0000_0000_0000;
      end else begin
         arr_op_done <= 1'b0;
         arr_rd_ack <= 1'b0;
         // data lines show no stale value outside an ack
         arr_rd_data <= ~arr_rd_data;
         if (arr_rd_req && !arr_rd_ack) begin
            rdc++;
            if (rdc >= rd_lat) begin
               rdc = 0;
               acks++;
               arr_rd_ack <= 1'b1;
               arr_rd_data <= {16'h5a5a, arr_rd_addr, 1'b1, 16'h5a5a, arr_rd_addr, 1'b0};
            end
         end
         if (arr_op_start) begin
            starts++;
            code = arr_op_code;
            page = arr_op_page;
            dw0 = arr_stage_data;
            opc = op_lat;
         end else if (opc > 0) begin
            opc--;
            if (opc == 0)
               arr_op_done <= 1'b1;
         end
      end
   end
endmodule

// file: tb_fcd_flash_command_decoder.sv
module tb_fcd_flash_command_decoder;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, arst_n = 1'b1, hsel_array = 1'b0, hsel_ctrl = 1'b0, hwrite = 1'b0;
   logic [18:0] haddr = 19'h0_0000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, hburst = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, rd, w;
   logic [7:0] op_lat = 8'h08, rd_lat = 8'h03;
   logic hready, hreadyout, hresp, er, arr_op_start, arr_op_done, arr_op_mismatch, arr_rd_req, arr_rd_ack;
   logic [1:0] arr_op_code;
   logic [10:0] arr_op_page;
   logic [3:0] arr_stage_idx;
   logic [63:0] arr_stage_data, arr_rd_data;
   logic [17:3] arr_rd_addr;
   int mismatches = 0, checks = 0, exp_starts = 0, k, n0;
   assign hready = hreadyout;
   fcd_flash_command_decoder fcd_flash_command_decoder_i (.clock, .arst_n, .hsel_array, .hsel_ctrl,
      .haddr, .htrans, .hwrite, .hsize, .hburst, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
      .arr_op_start, .arr_op_code, .arr_op_page, .arr_op_done, .arr_op_mismatch, .arr_stage_idx,
      .arr_stage_data, .arr_rd_req, .arr_rd_addr, .arr_rd_ack, .arr_rd_data);
   fcd_array_model fcd_array_model_i (.clock, .arst_n, .op_lat, .rd_lat, .arr_op_start, .arr_op_code,
      .arr_op_page, .arr_op_done, .arr_op_mismatch, .arr_stage_idx, .arr_stage_data, .arr_rd_req,
      .arr_rd_addr, .arr_rd_ack, .arr_rd_data);
   initial forever #10 clock = ~clock;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one bus transfer, entered just after a rising edge
   task automatic xfer(input logic arr, input logic wr_en, input logic [18:0] a, input logic [2:0] sz,
         input logic [2:0] b, input logic [31:0] d);
      int n;
      #1;
      hsel_array = arr;
      hsel_ctrl = !arr;
      haddr = a;
      hwrite = wr_en;
      hsize = sz;
      hburst = b;
      htrans = 2'h2;
      @(posedge clock);
      #1;
      htrans = 2'h0;
      hwdata = d << {a[1:0], 3'h0};
      n = 0;
      while (hreadyout !== 1'b1 && n < 3000) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 3000)
         mismatches++;
      // settled data phase values, taken before the closing edge
      rd = hrdata;
      er = hresp;
      @(posedge clock);
   endtask
   task automatic wr(input logic [18:0] a, input logic [31:0] d);
      xfer(1'b0, 1'b1, a, 3'h2, 3'h0, d);
   endtask
   task automatic rdr(input logic [18:0] a);
      xfer(1'b0, 1'b0, a, 3'h2, 3'h0, 32'h0000_0000);
   endtask
   task automatic rarr(input logic [18:0] a, input logic [2:0] b);
      xfer(1'b1, 1'b0, a, 3'h2, b, 32'h0000_0000);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] f);
      wr(fcd_pkg::OFF_CMD, {op, f});
   endtask
   task automatic idle_wait;
      int n;
      n = 0;
      do begin
         rdr(fcd_pkg::OFF_STATUS);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      if (n >= 200)
         mismatches++;
   endtask
   function automatic logic [23:0] pf(input logic [10:0] p);
      return {6'h00, p, 7'h7f};
   endfunction
   task automatic opchk(input logic [10:0] p, input logic [1:0] c, input logic [63:0] dw);
      idle_wait();
      exp_starts++;
      cmp("starts", exp_starts, fcd_array_model_i.starts);
      cmp("op code", c, fcd_array_model_i.code);
      if (c != 2'h2) begin
         cmp("op page", p, fcd_array_model_i.page);
         cmp("staging dword", dw, fcd_array_model_i.dw0);
      end
   endtask
   task automatic op(input logic [7:0] g, input logic [23:0] f, input logic [10:0] p, input logic [1:0] c,
         input logic [63:0] dw);
      cmd(g, f);
      opchk(p, c, dw);
   endtask
   initial begin
      #400000;
      mismatches++;
      print_verdict();
   end
   initial begin
      #1 arst_n = 1'b0;
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      rdr(fcd_pkg::OFF_STATUS);
      cmp("status", 32'h0000_0000, rd);
      rdr(fcd_pkg::OFF_DWCOUNT);
      cmp("dword count", 32'h0000_0010, rd);
      rdr(fcd_pkg::OFF_CMD);
      cmp("command readback", 32'h0000_0000, rd);
      $display("test reset done");
      op(fcd_pkg::OP_UNLOCK, 24'hff_ffff, 11'h000, 2'h2, 64'h0);
      wr(fcd_pkg::OFF_WSB, 32'h1111_0000);
      wr(fcd_pkg::OFF_WSB + 19'h0_0004, 32'h2222_0001);
      wr(fcd_pkg::OFF_DWCOUNT, 32'h0000_0001);
      cmd(fcd_pkg::OP_PROG_ADDR, pf(11'h5a5));
      cmd(fcd_pkg::OP_PROG_LOAD, 24'h00_0000);
      idle_wait();
      rdr(fcd_pkg::OFF_SPB);
      cmp("staging word", 32'h1111_0000, rd);
      op(fcd_pkg::OP_PROG_GO, 24'hff_ffff, 11'h5a5, 2'h0, 64'h2222_0001_1111_0000);
      wr(fcd_pkg::OFF_WSB, 32'h3333_0002);
      cmd(fcd_pkg::OP_PROG_ADDR, pf(11'h002));
      op(fcd_pkg::OP_PROG_GO, 24'h00_0000, 11'h002, 2'h0, 64'h2222_0001_1111_0000);
      op(fcd_pkg::OP_PROG_ALL, pf(11'h7ff), 11'h7ff, 2'h0, 64'h2222_0001_3333_0002);
      op(fcd_pkg::OP_VER_ALL, pf(11'h001), 11'h001, 2'h1, 64'h2222_0001_3333_0002);
      cmd(fcd_pkg::OP_VER_ADDR, pf(11'h400));
      cmd(fcd_pkg::OP_VER_LOAD, 24'hff_ff98);
      idle_wait();
      rdr(fcd_pkg::OFF_SPB + 19'h0_0018);
      cmp("staging word", 32'h3333_0002, rd);
      op(fcd_pkg::OP_VER_GO, 24'hff_ffff, 11'h400, 2'h1, 64'h2222_0001_3333_0002);
      w = {fcd_pkg::OP_VER_ALL, pf(11'h155)};
      for (int i = 3; i >= 0; i--)
         xfer(1'b0, 1'b1, fcd_pkg::OFF_CMD + 19'(i), 3'h0, 3'h0, 32'(w[8 * i +: 8]));
      opchk(11'h155, 2'h1, 64'h2222_0001_3333_0002);
      $display("test commands done");
      op_lat <= 8'h3c;
      cmd(fcd_pkg::OP_PROG_GO, 24'h00_0000);
      exp_starts++;
      rdr(fcd_pkg::OFF_STATUS);
      cmp("status", 32'h0000_0001, rd);
      cmd(fcd_pkg::OP_VER_GO, 24'h00_0000);
      rdr(fcd_pkg::OFF_STATUS);
      cmp("status", 32'h0000_0003, rd);
      rarr(19'h0_0100, 3'h0);
      cmp("stalled read", 32'h5a5a_0040, rd);
      op_lat <= 8'h08;
      cmd(fcd_pkg::OP_UNLOCK, 24'h00_0000);
      rdr(fcd_pkg::OFF_STATUS);
      cmp("status", 32'h0000_0002, rd);
      cmp("starts", exp_starts, fcd_array_model_i.starts);
      wr(fcd_pkg::OFF_CLEAR, 32'h0000_0002);
      rdr(fcd_pkg::OFF_STATUS);
      cmp("status", 32'h0000_0000, rd);
      op(fcd_pkg::OP_UNLOCK, 24'h00_0000, 11'h000, 2'h2, 64'h0);
      $display("test deny done");
      n0 = fcd_array_model_i.acks;
      rarr(19'h0_0104, 3'h0);
      cmp("hit read", 32'h5a5a_0041, rd);
      for (int i = 0; i < 8; i++) begin
         k = (3 + i) % 8;
         rarr(19'h0_0200 + 19'(4 * k), i == 0 ? fcd_pkg::HBURST_WRAP8 : 3'h0);
         cmp("burst word", {16'h5a5a, 16'h0080 + 16'(k)}, rd);
      end
      cmp("array fetches", n0 + 4, fcd_array_model_i.acks);
      xfer(1'b1, 1'b1, 19'h0_0200, 3'h2, 3'h0, 32'hdead_beef);
      cmp("error response", 1'b1, er);
      rarr(19'h0_0200, 3'h0);
      cmp("array word", 32'h5a5a_0080, rd);
      $display("test reads done");
      print_verdict();
   end
endmodule
